// file: dv/dmm_attr_monitor.sv
// Port checker of the attribute unit
`timescale 1ns/1ns
`default_nettype none
module dmm_attr_monitor
  import dmm_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  prot_en,
  input wire logic                  ifetch,
  input wire logic                  iexec,
  input wire logic                  iexecute_never,
  input wire logic                  iblock,
  input wire logic [31:0]           daddr,
  input wire logic                  dvalid,
  input wire logic [1:0]            dsize,
  input wire logic                  dready,
  input wire dmm_pkg::dmm_region_t  dregion,
  input wire dmm_pkg::dmm_memtype_t dmemtype,
  input wire logic                  dshareable,
  input wire logic                  dexecute_never,
  input wire logic                  dfault,
  input wire logic                  bus_valid,
  input wire logic                  bus_write,
  input wire logic                  bus_big_endian,
  input wire logic                  bus_bufferable,
  input wire logic                  bus_speculative_ok,
  input wire logic                  bus_outstanding,
  input wire logic                  exc_return,
  input wire logic                  hard_error_exception,
  input wire logic [1:0]            fault_cause,
  input wire logic                  handler_mode,
  input wire logic [5:0]            exc_number
);
  logic cpb;
  logic xn_run;
  assign cpb = daddr[31:20] == 12'hE00;
  assign xn_run = iexec && iexecute_never;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Fetch blocking, fault entry and handler return
  // ----
  sequence s_err(logic [1:0] cause);
    hard_error_exception && fault_cause == cause && handler_mode && exc_number == EXC_HARD_ERR;
  endsequence
  property p_fetch_block;
    ifetch && iexecute_never |-> iblock;
  endproperty
  a_fetch_block: assert property (p_fetch_block) else $error("fetch not blocked");
  property p_xn_fault;
    xn_run && !(dvalid && dfault) |=> s_err(CAUSE_XN);
  endproperty
  a_xn_fault: assert property (p_xn_fault) else $error("no fetch fault");
  property p_width_fault;
    dvalid && cpb && (dsize == SIZE_BYTE || dsize == SIZE_HALF) && !xn_run
      |-> dfault && dready && !bus_valid ##1 s_err(CAUSE_WIDTH);
  endproperty
  a_width_fault: assert property (p_width_fault) else $error("no width fault");
  property p_return;
    handler_mode && exc_return && !xn_run && !(dvalid && dfault)
      |=> !handler_mode && exc_number == EXC_NONE;
  endproperty
  a_return: assert property (p_return) else $error("handler not left");
  // ----
  // Attributes and ordering
  // ----
  property p_periph;
    !prot_en && daddr[31:29] == 3'b010
      |-> dregion == DMM_RGN_PERIPH && dmemtype == DMM_MT_DEVICE && dexecute_never;
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral attrs");
  property p_cpb;
    cpb |-> dregion == DMM_RGN_CPB && dmemtype == DMM_MT_STRONG && dshareable && dexecute_never;
  endproperty
  a_cpb: assert property (p_cpb) else $error("core bus attrs");
  property p_so_stall;
    dvalid && !dfault && dmemtype == DMM_MT_STRONG && bus_outstanding |-> !bus_valid && !dready;
  endproperty
  a_so_stall: assert property (p_so_stall) else $error("ordered access passed");
  property p_buffer;
    bus_valid && bus_write |-> bus_bufferable == (dmemtype != DMM_MT_STRONG);
  endproperty
  a_buffer: assert property (p_buffer) else $error("write buffering");
  property p_endian;
    bus_valid && cpb |-> !bus_big_endian;
  endproperty
  a_endian: assert property (p_endian) else $error("core bus endian");
  property p_spec;
    bus_valid |-> bus_speculative_ok == (dmemtype == DMM_MT_NORMAL);
  endproperty
  a_spec: assert property (p_spec) else $error("speculation flag");
endmodule : dmm_attr_monitor
bind dmm_attr_unit dmm_attr_monitor u_mon (.*);
`default_nettype wire

// file: dv/dmm_attr_unit_tb_top.sv
// Testbench of the default memory map attribute unit
`timescale 1ns/1ns
`default_nettype none
module dmm_attr_unit_tb_top;
  import dmm_pkg::*;
  logic clk = 0, resetn = 0, prot_en = 0, iprot_hit = 0, ifetch = 0, iexec = 0;
  logic dvalid = 0, dwrite = 0, dbig_endian = 0, exc_return = 0;
  logic [31:0] iaddr = 0, daddr = 0, bus_addr;
  logic [1:0] dsize = 0, bus_size, fault_cause;
  logic [3:0] lat = 0, snap;
  logic [5:0] exc_number;
  dmm_region_t iregion, dregion;
  dmm_memtype_t dmemtype;
  logic dprot_hit = 0, dprot_shareable = 0, iprot_execute_never = 0;
  dmm_memtype_t iprot_memtype = DMM_MT_NORMAL, dprot_memtype = DMM_MT_NORMAL;
  logic iexecute_never, iblock, dready, dshareable, dexecute_never, dfault, bus_valid;
  logic bus_write, bus_big_endian, bus_bufferable, bus_shareable, bus_speculative_ok;
  logic bus_ready, bus_done, bus_outstanding, hard_error_exception, handler_mode;
  int n_errors = 0, total_checks = 0;
  localparam logic [31:0] MA [14] = '{32'h0000_0000, 32'h1FFF_FFFF, 32'h2000_0000,
    32'h3FFF_FFFF, 32'h4000_0000, 32'h5FFF_FFFF, 32'h6000_0000, 32'h9FFF_FFFF,
    32'hA000_0000, 32'hDFFF_FFFF, 32'hE000_0000, 32'hE00F_FFFF, 32'hE010_0000, 32'hFFFF_FFFF};
  // Region code, memory type, execute-never
  localparam logic [5:0] ME [14] = '{6'h00, 6'h00, 6'h08, 6'h08, 6'h13, 6'h13, 6'h18,
    6'h18, 6'h23, 6'h23, 6'h2D, 6'h2D, 6'h32, 6'h32};
  dmm_attr_unit uut (.*);
  dmm_bus_model u_bus (.clk, .resetn, .bus_valid, .lat, .bus_ready, .bus_done, .bus_outstanding);
  always #5 clk = ~clk;
  // ----
  // Shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  // Holds the request until taken; ends on the taking edge so callers may chain
  task automatic req(input logic [31:0] a, input logic w, input logic [1:0] s, output int n);
    @(negedge clk);
    daddr = a;
    dwrite = w;
    dsize = s;
    dvalid = 1;
    n = 0;
    #1;
    while (!dready && n < 40)
    begin
      @(negedge clk);
      n++;
      #1;
    end
    snap = {dfault, bus_valid, bus_big_endian, bus_bufferable};
    check(dready, 1);
    check(bus_addr, a);
    check({bus_write, bus_size}, {w, s});
    @(posedge clk);
  endtask : req
  task automatic drain;
    for (int i = 0; i < 40 && bus_outstanding; i++)
      @(negedge clk);
    check(bus_outstanding, 0);
  endtask : drain
  // ----
  // Scenarios
  // ----
  task automatic t_map;
    for (int i = 0; i < 14; i++)
    begin
      @(negedge clk);
      daddr = MA[i];
      iaddr = MA[i];
      #1;
      check({dregion, dmemtype}, ME[i][5:1]);
      check(iregion, ME[i][5:3]);
      if (ME[i][5:3] != DMM_RGN_SYSDEV) check({dexecute_never, iexecute_never}, {2{ME[i][0]}});
      if (ME[i][2:1] == DMM_MT_STRONG) check(dshareable, 1);
    end
  endtask : t_map
  task automatic t_xn;
    @(negedge clk);
    iaddr = 32'h4000_0000;
    ifetch = 1;
    #1 check(iblock, 1);
    iexec = 1;
    @(negedge clk);
    iexec = 0;
    check({hard_error_exception, fault_cause, handler_mode, exc_number}, {1'b1, CAUSE_XN, 1'b1, EXC_HARD_ERR});
    @(negedge clk);
    check(hard_error_exception, 0);
    exc_return = 1;
    iaddr = 32'h2000_0000;
    iexec = 1;
    @(negedge clk);
    exc_return = 0;
    iexec = 0;
    ifetch = 0;
    check({hard_error_exception, handler_mode, exc_number}, 0);
  endtask : t_xn
  task automatic t_width;
    int w;
    dbig_endian = 1;
    for (int s = 0; s < 3; s++)
    begin
      req(32'hE000_ED00, 0, s[1:0], w);
      check(snap, s < 2 ? 4'b1000 : 4'b0100);
      @(negedge clk);
      dvalid = 0;
      check({hard_error_exception, fault_cause}, {s < 2, CAUSE_WIDTH});
    end
    drain;
    req(32'h2000_0000, 0, 2'b11, w);
    check(snap, 4'b1010);
    @(negedge clk);
    dvalid = 0;
    lat = 4;
    check(hard_error_exception, 0);
  endtask : t_width
  task automatic t_order;
    int w;
    dbig_endian = 0;
    req(32'h4000_0000, 1, SIZE_WORD, w);
    check({w, snap}, 4'b0101);
    req(32'h4000_0004, 0, SIZE_WORD, w);
    check(w != 0, 1);
    req(32'hE000_E010, 1, SIZE_WORD, w);
    check({w != 0, snap}, 5'b10100);
    req(32'h2000_0000, 0, SIZE_WORD, w);
    check(w != 0, 1);
    req(32'h2000_0004, 1, SIZE_HALF, w);
    check({w, snap}, 4'b0101);
    req(32'h6000_0000, 0, SIZE_BYTE, w);
    check(w, 0);
    req(32'hA000_0000, 0, SIZE_WORD, w);
    check(w, 0);
    @(negedge clk);
    dvalid = 0;
    drain;
  endtask : t_order
  task automatic t_prot;
    @(negedge clk);
    daddr = 32'hA000_0000;
    #1 check({dshareable, bus_shareable}, 2'b11);
    @(negedge clk);
    daddr = 32'hC000_0000;
    #1 check({dshareable, bus_shareable}, 2'b00);
    @(negedge clk);
    prot_en = 1;
    iprot_hit = 1;
    iprot_execute_never = 1;
    dprot_hit = 1;
    dprot_shareable = 1;
    iaddr = 32'h2000_0000;
    daddr = 32'h4000_0000;
    #1 check({dmemtype, dshareable, dexecute_never, iexecute_never}, 5'b00101);
    @(negedge clk);
    dprot_memtype = DMM_MT_STRONG;
    dprot_shareable = 0;
    daddr = 32'h2000_0000;
    #1 check({dmemtype, dshareable}, {DMM_MT_STRONG, 1'b1});
    @(negedge clk);
    daddr = 32'hE000_0000;
    #1 check({dmemtype, dshareable, dexecute_never}, {DMM_MT_STRONG, 2'b11});
    @(negedge clk);
    prot_en = 0;
  endtask : t_prot
  initial
  begin
    repeat (20) @(negedge clk);
    resetn = 1;
    check({hard_error_exception, handler_mode, exc_number, fault_cause}, 0);
    t_map;
    t_prot;
    t_xn;
    t_width;
    t_order;
    end_of_test;
  end
  initial
  begin
    #100000;
    n_errors++;
    end_of_test;
  end
endmodule : dmm_attr_unit_tb_top
`default_nettype wire

// file: dv/dmm_bus_model.sv
// System bus model: takes requests, completes them after a set latency
`timescale 1ns/1ns
`default_nettype none
module dmm_bus_model
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       bus_valid,
  input  wire logic [3:0] lat,
  output var logic        bus_ready,
  output var logic        bus_done,
  output var logic        bus_outstanding
);
  logic [3:0] n;
  logic [3:0] t;
  logic       fin;
  logic       iss;
  assign bus_ready = resetn;
  assign iss = bus_valid && bus_ready;
  // Completions retire in issue order, one at a time, so ordering is not helped
  assign fin = n != 4'h0 && t == 4'h0;
  assign bus_outstanding = n != 4'h0;
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      n <= 4'h0;
      t <= 4'h0;
      bus_done <= 1'b0;
    end
    else
    begin
      bus_done <= fin;
      n <= n + {3'h0, iss} - {3'h0, fin};
      if ((iss && n == 4'h0) || fin)
        t <= lat;
      else if (t != 4'h0)
        t <= t - 4'h1;
    end
  end
endmodule : dmm_bus_model
`default_nettype wire

// file: rtl/dmm_attr_unit.sv
// Default memory map attribute unit: fetch checks, data checks, ordering and fault entry
`timescale 1ns/1ns
`default_nettype none
module dmm_attr_unit
  import dmm_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  // Protection unit override
  input  wire logic              prot_en,
  input  wire logic              iprot_hit,
  input  wire dmm_pkg::dmm_memtype_t iprot_memtype,
  input  wire logic              iprot_execute_never,
  input  wire logic              dprot_hit,
  input  wire dmm_pkg::dmm_memtype_t dprot_memtype,
  input  wire logic              dprot_shareable,
  // Instruction side
  input  wire logic [31:0]       iaddr,
  input  wire logic              ifetch,
  input  wire logic              iexec,
  output dmm_pkg::dmm_region_t   iregion,
  output logic                   iexecute_never,
  output logic                   iblock,
  // Data side request from the load/store unit
  input  wire logic [31:0]       daddr,
  input  wire logic              dvalid,
  input  wire logic              dwrite,
  input  wire logic [1:0]        dsize,
  input  wire logic              dbig_endian,
  output logic                   dready,
  output dmm_pkg::dmm_region_t   dregion,
  output dmm_pkg::dmm_memtype_t  dmemtype,
  output logic                   dshareable,
  output logic                   dexecute_never,
  output logic                   dfault,
  // System bus side
  output logic                   bus_valid,
  output logic [31:0]            bus_addr,
  output logic                   bus_write,
  output logic [1:0]             bus_size,
  output logic                   bus_big_endian,
  output logic                   bus_bufferable,
  output logic                   bus_shareable,
  output logic                   bus_speculative_ok,
  input  wire logic              bus_ready,
  input  wire logic              bus_done,
  input  wire logic              bus_outstanding,
  // Exception entry
  input  wire logic              exc_return,
  output logic                   hard_error_exception,
  output logic [1:0]             fault_cause,
  output logic                   handler_mode,
  output logic [5:0]             exc_number
);
  import dmm_pkg::*;

  // ----------------------------------------------------------------
  // Attribute decode
  // ----------------------------------------------------------------
  dmm_memtype_t imt;
  logic         ish;
  logic         ibuf;
  logic         ile;
  logic         dbuf;
  logic         dle;

  dmm_decode u_idec (
    .addr               (iaddr),
    .prot_en            (prot_en),
    .prot_hit           (iprot_hit),
    .prot_memtype       (iprot_memtype),
    .prot_shareable     (1'b0),
    .prot_execute_never (iprot_execute_never),
    .region             (iregion),
    .memtype            (imt),
    .shareable          (ish),
    .execute_never      (iexecute_never),
    .bufferable         (ibuf),
    .little_endian_only (ile)
  );

  dmm_decode u_ddec (
    .addr               (daddr),
    .prot_en            (prot_en),
    .prot_hit           (dprot_hit),
    .prot_memtype       (dprot_memtype),
    .prot_shareable     (dprot_shareable),
    .prot_execute_never (1'b0),
    .region             (dregion),
    .memtype            (dmemtype),
    .shareable          (dshareable),
    .execute_never      (dexecute_never),
    .bufferable         (dbuf),
    .little_endian_only (dle)
  );

  // ----------------------------------------------------------------
  // Access checks
  // ----------------------------------------------------------------
  // Fetch from an execute-never region is blocked at once; the fault
  // is only raised if the fetched word actually reaches execution.
  assign iblock = ifetch && iexecute_never;                      // see (RQ8)

  logic xn_exec;
  logic width_err;
  logic ordered;
  logic last_ordered;
  logic last_strong;

  assign xn_exec   = iexec && iexecute_never;                    // see (RQ8)
  // Only word size legal in the core peripheral bus window
  assign width_err = dvalid && (dregion == DMM_RGN_CPB) && (dsize != SIZE_WORD); // see (RQ6) (RQ23)
  // Size code 2'b11 has no meaning; the access is faulted but raises no error exception outside the core peripheral bus window
  assign dfault    = width_err || (dvalid && dsize == SIZE_RSVD); // see (RQ15) (RQ22)

  // Device and strongly-ordered accesses must wait while an earlier
  // ordered access is still in flight; Normal waits only behind strongly-ordered.
  always_comb
  begin
    unique case (dmemtype)
      DMM_MT_STRONG: ordered = bus_outstanding;                  // see (RQ11)
      DMM_MT_DEVICE: ordered = bus_outstanding && last_ordered;  // see (RQ10)
      default:       ordered = 1'b0;                             // see (RQ9)
    endcase
  end

  // ----------------------------------------------------------------
  // Ordering tracker
  // ----------------------------------------------------------------
  logic next_last_ordered;
  logic next_last_strong;

  always_comb
  begin
    next_last_ordered = last_ordered;
    next_last_strong  = last_strong;
    if (bus_valid && bus_ready)
    begin
      // Sticky while earlier ordered accesses are in flight, so a Normal
      // access in between cannot let a later Device access overtake
      next_last_ordered = (bus_outstanding && last_ordered) || (dmemtype != DMM_MT_NORMAL);
      next_last_strong  = (bus_outstanding && last_strong) || (dmemtype == DMM_MT_STRONG);
    end
    else if (bus_done && !bus_outstanding)
    begin
      next_last_ordered = 1'b0;
      next_last_strong  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      last_ordered <= 1'b0;
      last_strong  <= 1'b0;
    end
    else
    begin
      last_ordered <= next_last_ordered;
      last_strong  <= next_last_strong;
    end
  end

  // A Normal access after a strongly-ordered one also waits
  logic stall;
  assign stall = ordered || (bus_outstanding && last_strong);    // see (RQ11) (RQ20)

  // ----------------------------------------------------------------
  // Bus issue
  // ----------------------------------------------------------------
  assign bus_valid          = dvalid && !dfault && !stall;
  assign dready             = dfault || (bus_valid && bus_ready);
  assign bus_addr           = daddr;
  assign bus_write          = dwrite;
  assign bus_size           = dsize;                             // see (RQ15)
  assign bus_big_endian     = dbig_endian && !dle;               // see (RQ16)
  assign bus_bufferable     = dwrite && dbuf;                    // see (RQ12)
  assign bus_shareable      = dshareable;                        // see (RQ14)
  assign bus_speculative_ok = (dmemtype == DMM_MT_NORMAL);       // see (RQ9)

  // ----------------------------------------------------------------
  // Fault and handler mode
  // ----------------------------------------------------------------
  logic       next_hard_error_exception;
  logic [1:0] next_fault_cause;
  logic       next_handler_mode;
  logic [5:0] next_exc_number;

  always_comb
  begin
    next_hard_error_exception = 1'b0;
    next_fault_cause          = fault_cause;
    next_handler_mode         = handler_mode;
    next_exc_number           = exc_number;
    if (exc_return)
    begin
      next_handler_mode = 1'b0;
      next_exc_number   = EXC_NONE;
    end
    // A new fault wins over a return in the same cycle
    if (xn_exec || width_err)
    begin
      next_hard_error_exception = 1'b1;                          // see (RQ8)
      next_fault_cause          = xn_exec ? CAUSE_XN : CAUSE_WIDTH; // see (RQ23)
      next_handler_mode         = 1'b1;                          // see (RQ17)
      next_exc_number           = EXC_HARD_ERR;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      // Reset leaves the core in thread mode
      hard_error_exception <= 1'b0;
      fault_cause          <= CAUSE_NONE;
      handler_mode         <= 1'b0;                              // see (RQ17)
      exc_number           <= EXC_NONE;
    end
    else
    begin
      hard_error_exception <= next_hard_error_exception;
      fault_cause          <= next_fault_cause;
      handler_mode         <= next_handler_mode;
      exc_number           <= next_exc_number;
    end
  end

endmodule : dmm_attr_unit
`default_nettype wire

// file: rtl/dmm_decode.sv
// Combinational region and attribute decoder for one address
`timescale 1ns/1ns
`default_nettype none
module dmm_decode
  import dmm_pkg::*;
(
  input  wire logic [31:0]       addr,
  input  wire logic              prot_en,
  input  wire logic              prot_hit,
  input  wire dmm_pkg::dmm_memtype_t prot_memtype,
  input  wire logic              prot_shareable,
  input  wire logic              prot_execute_never,
  output dmm_pkg::dmm_region_t   region,
  output dmm_pkg::dmm_memtype_t  memtype,
  output logic                   shareable,
  output logic                   execute_never,
  output logic                   bufferable,
  output logic                   little_endian_only
);
  import dmm_pkg::*;

  dmm_memtype_t dflt_mt;
  logic         dflt_sh;
  logic         dflt_xn;

  // Whole 32-bit space decodes to exactly one region
  always_comb
  begin
    region  = DMM_RGN_CODE;                                      // see (RQ18)
    dflt_mt = DMM_MT_NORMAL;
    dflt_sh = 1'b0;
    dflt_xn = 1'b0;
    if (addr >= SYSDEV_BASE)
    begin
      region  = DMM_RGN_SYSDEV;                                  // see (RQ7)
      dflt_mt = DMM_MT_DEVICE;
      dflt_xn = 1'b1;
    end
    else if (addr >= CPB_BASE)
    begin
      region  = DMM_RGN_CPB;                                     // see (RQ6)
      dflt_mt = DMM_MT_STRONG;
      dflt_xn = 1'b1;
    end
    else if (addr >= EXTDEV_BASE)
    begin
      region  = DMM_RGN_EXTDEV;                                  // see (RQ5)
      dflt_mt = DMM_MT_DEVICE;
      dflt_sh = addr < EXTDEV_NS_BASE;
      dflt_xn = 1'b1;
    end
    else if (addr >= EXTRAM_BASE)
    begin
      region  = DMM_RGN_EXTRAM;                                  // see (RQ4)
    end
    else if (addr >= PERIPH_BASE)
    begin
      region  = DMM_RGN_PERIPH;                                  // see (RQ3)
      dflt_mt = DMM_MT_DEVICE;
      dflt_xn = 1'b1;
    end
    else if (addr >= SRAM_BASE)
    begin
      region  = DMM_RGN_SRAM;                                    // see (RQ2)
    end
    else
    begin
      region  = DMM_RGN_CODE;                                    // see (RQ1)
    end
  end

  always_comb
  begin
    // Core peripheral bus stays fixed even when the protection unit is on
    if (prot_en && prot_hit && region != DMM_RGN_CPB)
    begin
      memtype       = prot_memtype;                              // see (RQ21)
      shareable     = prot_shareable;
      execute_never = prot_execute_never;
    end
    else
    begin
      memtype       = dflt_mt;
      shareable     = dflt_sh;
      execute_never = dflt_xn;
    end
    if (memtype == DMM_MT_STRONG)
      shareable = 1'b1;                                          // see (RQ13)
  end

  assign bufferable         = (memtype != DMM_MT_STRONG);        // see (RQ12)
  assign little_endian_only = (region == DMM_RGN_CPB);           // see (RQ16)

endmodule : dmm_decode
`default_nettype wire

// file: rtl/dmm_pkg.sv
// Package of region map constants, attribute types and access codes for the attribute decoder
// Functional notes
// (RQ1) Code region 0 to 0x1FFFFFFF, Normal, executable
// (RQ2) SRAM region 0x20000000-0x3FFFFFFF, Normal, executable
// (RQ3) Peripheral region 0x40000000-0x5FFFFFFF, Device, execute-never
// (RQ4) External RAM 1GB from 0x60000000, Normal, executable
// (RQ5) External device 1GB from 0xA0000000, Device, execute-never
// (RQ6) Core peripheral bus: strongly-ordered, execute-never, word only
// (RQ7) Top 511MB from 0xE0100000 is Device region
// (RQ8) Executing execute-never fetch blocks access, raises error exception
// (RQ9) Normal accesses may be reordered or speculated
// (RQ10) Device kept ordered against Device and strongly-ordered
// (RQ11) Strongly-ordered kept ordered against all transactions
// (RQ12) Device writes bufferable; strongly-ordered writes never buffered
// (RQ13) Strongly-ordered always reported shareable
// (RQ14) Shareable regions kept coherent between bus masters
// (RQ15) Word, halfword and byte data accesses supported
// (RQ16) Fetch and core peripheral bus always little-endian
// (RQ17) Every exception except reset runs in handler mode
// (RQ18) One fixed memory map spanning 4GB
// (RQ19) Software uses barrier for ordered Normal accesses
// (RQ20) Ordered pairs: earlier access observed before later
// (RQ21) Protection unit overrides default attributes when enabled; the code keeps the core peripheral bus attributes fixed
// (RQ22) Attributes presented combinationally with the address
// (RQ23) Sub-word access in core peripheral bus faults
package dmm_pkg;

  localparam int ADDR_W = 32;

  // Region bases; each region ends one below the next base
  localparam logic [31:0] CODE_BASE    = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE    = 32'h2000_0000;
  localparam logic [31:0] PERIPH_BASE  = 32'h4000_0000;
  localparam logic [31:0] EXTRAM_BASE  = 32'h6000_0000;
  localparam logic [31:0] EXTDEV_BASE  = 32'hA000_0000;
  localparam logic [31:0] CPB_BASE     = 32'hE000_0000;
  localparam logic [31:0] SYSDEV_BASE  = 32'hE010_0000;
  // Boundary between shareable and non-shareable external device space
  localparam logic [31:0] EXTDEV_NS_BASE = 32'hC000_0000;

  typedef enum logic [2:0] {
    DMM_RGN_CODE   = 3'b000,
    DMM_RGN_SRAM   = 3'b001,
    DMM_RGN_PERIPH = 3'b010,
    DMM_RGN_EXTRAM = 3'b011,
    DMM_RGN_EXTDEV = 3'b100,
    DMM_RGN_CPB    = 3'b101,
    DMM_RGN_SYSDEV = 3'b110
  } dmm_region_t;

  typedef enum logic [1:0] {
    DMM_MT_NORMAL = 2'b00,
    DMM_MT_DEVICE = 2'b01,
    DMM_MT_STRONG = 2'b10
  } dmm_memtype_t;

  // Access size codes
  localparam logic [1:0] SIZE_BYTE = 2'b00;
  localparam logic [1:0] SIZE_HALF = 2'b01;
  localparam logic [1:0] SIZE_WORD = 2'b10;
  localparam logic [1:0] SIZE_RSVD = 2'b11;

  // Fault cause codes reported with the error exception
  localparam logic [1:0] CAUSE_NONE  = 2'b00;
  localparam logic [1:0] CAUSE_XN    = 2'b01;
  localparam logic [1:0] CAUSE_WIDTH = 2'b10;

  // Exception number of the error exception, used for handler mode entry
  localparam logic [5:0] EXC_NONE      = 6'h00;
  localparam logic [5:0] EXC_HARD_ERR  = 6'h03;

endpackage : dmm_pkg
